//--- shared/cpu_exception_entry_return_map.vh
/*
 * Register offsets, field positions, reset values and state codes of the
 * exception entry and return unit.
 * Assumes inclusion by the unit's design file only; definitions only.
 */
`ifndef CPU_EXCEPTION_ENTRY_RETURN_MAP_VH
`define CPU_EXCEPTION_ENTRY_RETURN_MAP_VH

// ****************************************************************
// Register word offsets (byte address bits 7:2)
// ****************************************************************
`define OFS_MACHINE_STATE   6'h00
`define OFS_SAVED_RETURN    6'h01
`define OFS_SAVED_STATE     6'h02
`define OFS_SET_EN_RECOV    6'h03
`define OFS_SET_RECOV_ONLY  6'h04
`define OFS_UNIT_STATUS     6'h05

// ****************************************************************
// Machine state fields, bit 0 = least significant
// ****************************************************************
`define MSR_EE_BIT          15
`define MSR_RI_BIT          1
`define MSR_SAVED_HI        15
`define MSR_RESET           32'h00000000
`define SRR_RESET           32'h00000000

// ****************************************************************
// Vector layout: vector = base | (type << shift)
// ****************************************************************
`define VEC_SHIFT           8

// ****************************************************************
// Sequencer states, one-hot
// ****************************************************************
`define ST_IDLE             4'h1
`define ST_DRAIN            4'h2
`define ST_SAVE             4'h4
`define ST_JUMP             4'h8

`endif

//--- sim/core_model.sv
/* Far-side model: keeps the core busy for a while after entry starts.
   Assumes the unit raises holdFetch on entry and samples coreBusy. */
module core_model (
    input  wire logic       mclk,      // Core clock
    input  wire logic       resetn,    // Reset, active low
    input  wire logic       holdFetch, // Entry in progress
    input  wire logic [3:0] busyLen,   // Cycles still in flight
    output logic            coreBusy   // In-flight work
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busyQ;
    logic       holdQ;
    logic       newEntry;
    // Work is already in flight in the first drain cycle, not one later
    assign newEntry = holdFetch && !holdQ;
    assign coreBusy = (newEntry && busyLen != 4'h0) || (busyQ != 4'h0);
    always @(posedge mclk) begin
        holdQ <= resetn & holdFetch;
        if (!resetn) busyQ <= 4'h0;
        else if (newEntry && busyLen != 4'h0) busyQ <= busyLen - 4'h1;
        else if (busyQ != 4'h0) busyQ <= busyQ - 4'h1;
    end
endmodule

//--- sim/exc_unit_checker.sv
/* Port checker of the exception unit.
   Assumes binding into the unit; one clock, reset low. */
module exc_unit_checker #(parameter TYPE_W = 4, parameter VEC_BASE = 32'h00000000) (
    input wire logic mclk, resetn, wbCyc, wbStb, wbWe, wbAck, excReq, dbgReq, rfiReq,
    input wire logic coreBusy, holdFetch, fetchLoad, extIrqEnable, recoverable,
    input wire logic [7:0]        wbAdr,
    input wire logic [31:0]       wbDatO, fetchAddr,
    input wire logic [TYPE_W-1:0] excType
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [TYPE_W-1:0] typeQ;
    logic              busW;
    logic              quietQ;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Write lands at the edge that raises ack; sequencer must be quiet then
    always @(posedge mclk) quietQ <= !holdFetch && !(rfiReq && !excReq && !dbgReq);
    assign busW = wbCyc && wbStb && wbAck && wbWe && quietQ;
    // Debug entries always use the all-ones type
    always @(posedge mclk) begin
        if ((excReq || dbgReq) && !holdFetch) typeQ <= dbgReq ? {TYPE_W{1'b1}} : excType;
    end
    property p_ack; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
    a_ack: assert property (p_ack) else $error("request not acknowledged");
    property p_ackOnce; wbAck |=> !wbAck; endproperty
    a_ackOnce: assert property (p_ackOnce) else $error("ack longer than one cycle");
    property p_datIdle; !wbAck |-> wbDatO == 32'h0; endproperty
    a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
    property p_drain; holdFetch && coreBusy |=> !fetchLoad; endproperty
    a_drain: assert property (p_drain) else $error("redirect while busy");
    property p_entry; $rose(holdFetch) |-> ##[3:40] fetchLoad; endproperty
    a_entry: assert property (p_entry) else $error("entry never redirects");
    property p_vector; fetchLoad && $past(holdFetch) |-> fetchAddr == (VEC_BASE | (32'(typeQ) << 8)); endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");
    property p_mask; fetchLoad && $past(holdFetch) |-> !extIrqEnable && !recoverable; endproperty
    a_mask: assert property (p_mask) else $error("flags not cleared on entry");
    property p_rfi; rfiReq && !excReq && !dbgReq && !holdFetch |=> fetchLoad; endproperty
    a_rfi: assert property (p_rfi) else $error("return without redirect");
    property p_setBoth; busW && wbAdr[7:2] == 6'h03 |-> extIrqEnable && recoverable; endproperty
    a_setBoth: assert property (p_setBoth) else $error("set-enable port failed");
    property p_setRec;
        busW && wbAdr[7:2] == 6'h04 |-> recoverable && extIrqEnable == $past(extIrqEnable);
    endproperty
    a_setRec: assert property (p_setRec) else $error("recoverable port failed");
endmodule
bind cpu_exception_entry_return exc_unit_checker #(.TYPE_W(TYPE_W), .VEC_BASE(VEC_BASE)) i_chk (
    .mclk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAck, .excReq, .dbgReq, .rfiReq, .coreBusy,
    .holdFetch, .fetchLoad, .extIrqEnable, .recoverable, .wbAdr, .wbDatO, .fetchAddr, .excType);

//--- sim/tb_top.sv
/* Testbench of the exception unit: bus accesses, entries and returns.
   Assumes the unit and the core model compile before it. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, excReq = 0, dbgReq = 0;
    logic        rfiReq = 0;
    logic [7:0]  wbAdr = 8'h00;
    logic [3:0]  wbSel = 4'hf, excType = 4'h0, busyLen = 4'h3;
    logic [31:0] wbDatI = 32'h0, nextPc = 32'h0;
    wire  [31:0] wbDatO, fetchAddr, machineState;
    wire         wbAck, fetchLoad, holdFetch, extIrqEnable, recoverable, coreBusy;
    int          nFail = 0, checkCount = 0;
    always #4 mclk = ~mclk;
    cpu_exception_entry_return i_dut (.mclk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
        .wbDatI, .wbDatO, .wbAck, .excReq, .excType, .dbgReq, .rfiReq, .coreBusy, .nextPc,
        .fetchLoad, .fetchAddr, .holdFetch, .machineState, .extIrqEnable, .recoverable);
    core_model i_core (.mclk, .resetn, .holdFetch, .busyLen, .coreBusy);
    task end_sim;
        if (nFail == 0 && checkCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait on a design flag; 0 waits for ack, 1 for a redirect
    task waitFor(input logic which);
        for (int i = 0; i <= 60; i++) begin
            @(posedge mclk);
            if ((which ? fetchLoad : wbAck) === 1'b1) break;
            if (i == 60) begin
                nFail++;
                end_sim();
            end
        end
    endtask
    // Single classic cycle; a read compares its data with d
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, w, a, d};
        waitFor(1'b0);
        if (!w) chk(wbDatO, d);
        {wbCyc, wbStb, wbWe} <= 3'b000;
    endtask
    task enter(input logic d, input logic [3:0] t, input logic [31:0] pc);
        @(posedge mclk);
        {excReq, dbgReq, excType, nextPc} <= {!d, d, t, pc};
        @(posedge mclk);
        {excReq, dbgReq} <= 2'b00;
        waitFor(1'b1);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        wb(0, 8'h00, 32'h0);
        wb(1, 8'h00, 32'hffff8002);
        enter(0, 4'h5, 32'h100);
        chk(fetchAddr, 32'h500);
        chk({30'h0, extIrqEnable, recoverable}, 32'h0);
        wb(0, 8'h04, 32'h100);
        wb(0, 8'h08, 32'h8002);
        wb(0, 8'h00, 32'hffff0000);
        busyLen <= 4'h0;
        enter(1, 4'h0, 32'h200);
        chk(fetchAddr, 32'hf00);
        wb(0, 8'h14, 32'h000000f1);
        wb(0, 8'h04, 32'h200);
        wb(0, 8'h08, 32'h0);
        wb(1, 8'h0c, 32'h0);
        wb(0, 8'h00, 32'hffff8002);
        wb(1, 8'h00, 32'h0);
        wb(1, 8'h10, 32'h5a5a5a5a);
        wb(0, 8'h00, 32'h2);
        chk({31'h0, recoverable}, 32'h1);
        wb(1, 8'h00, 32'h0);
        wb(1, 8'h04, 32'h1234);
        wb(1, 8'h08, 32'h8002);
        @(posedge mclk) rfiReq <= 1'b1;
        @(posedge mclk) rfiReq <= 1'b0;
        @(posedge mclk);
        chk({31'h0, fetchLoad}, 32'h1);
        chk(fetchAddr, 32'h1234);
        chk(machineState, 32'h8002);
        wb(0, 8'h3c, 32'h0);
        end_sim();
    end
endmodule

//--- src/cpu_exception_entry_return.v
/*
 * Exception entry and return sequencer of a processor core, with the
 * machine state and both save/restore registers reachable over a classic
 * Wishbone slave.
 * Assumes the core reports in-flight work on coreBusy, offers the next
 * instruction address on nextPc, and follows fetchLoad/fetchAddr and
 * holdFetch. All inputs are on mclk; none needs synchronising.
 */
// The register addresses and register access over Wishbone are this design's own decisions.

`include "cpu_exception_entry_return_map.vh"

module cpu_exception_entry_return #(
    parameter TYPE_W   = 4,             // Width of exception type code
    parameter VEC_BASE = 32'h00000000   // Base of the vector table
) (
    input  wire              mclk,          // Core clock, 125 MHz
    input  wire              resetn,        // Synchronous reset, active low
    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    input  wire              wbCyc,         // Bus cycle
    input  wire              wbStb,         // Strobe
    input  wire              wbWe,          // Write enable
    input  wire [7:0]        wbAdr,         // Byte address
    input  wire [3:0]        wbSel,         // Byte lanes
    input  wire [31:0]       wbDatI,        // Write data
    output reg  [31:0]       wbDatO,        // Read data
    output reg               wbAck,         // Acknowledge
    // ****************************************************************
    // Core side
    // ****************************************************************
    input  wire              excReq,        // Exception request pulse
    input  wire [TYPE_W-1:0] excType,       // Type of requested exception
    input  wire              dbgReq,        // Debug exception request pulse
    input  wire              rfiReq,        // Return instruction executed
    input  wire              coreBusy,      // Instructions still in execution
    input  wire [31:0]       nextPc,        // Address of next instruction
    output reg               fetchLoad,     // Redirect fetch pulse
    output reg  [31:0]       fetchAddr,     // Redirect target
    output wire              holdFetch,     // No issue while entering
    output wire [31:0]       machineState,  // Current machine state
    output wire              extIrqEnable,  // Maskable interrupts enabled
    output wire              recoverable    // Recoverable flag
);

    localparam [TYPE_W-1:0] DBG_TYPE = {TYPE_W{1'b1}}; // Debug uses top vector

    reg  [31:0]       msr_q;
    reg  [31:0]       saved_return_address_reg_q;
    reg  [31:0]       saved_machine_state_reg_q;
    reg  [3:0]        state_q;
    reg  [TYPE_W-1:0] type_q;
    reg  [31:0]       msr_d;
    reg  [31:0]       saved_return_address_reg_d;
    reg  [31:0]       saved_machine_state_reg_d;
    wire              busReq;
    wire              wrStb;
    wire [5:0]        wordAdr;
    wire [31:0]       wrMask;
    wire [31:0]       vector;
    wire              idleCycle;
    wire              saveCycle;
    wire              jumpCycle;
    wire              rfiTake;

    assign busReq       = wbCyc & wbStb & ~wbAck;
    assign wrStb        = busReq & wbWe;
    assign wordAdr      = wbAdr[7:2];
    assign wrMask       = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
    assign vector       = VEC_BASE | ({{(32-TYPE_W){1'b0}}, type_q} << `VEC_SHIFT);
    assign holdFetch    = (state_q != `ST_IDLE);
    assign machineState = msr_q;
    assign extIrqEnable = msr_q[`MSR_EE_BIT];
    assign recoverable  = msr_q[`MSR_RI_BIT];
    assign idleCycle    = (state_q == `ST_IDLE);
    assign saveCycle    = (state_q == `ST_SAVE);
    assign jumpCycle    = (state_q == `ST_JUMP);
    assign rfiTake      = idleCycle & rfiReq & ~excReq & ~dbgReq;

    // ****************************************************************
    // Entry sequencer
    // ****************************************************************
    // Saved state and fetch redirect come only from these registers; no
    // frame is pushed anywhere by hardware.
    always @(posedge mclk) begin
        if (!resetn) begin
            state_q   <= `ST_IDLE;
            type_q    <= {TYPE_W{1'b0}};
            fetchLoad <= 1'b0;
            fetchAddr <= 32'h00000000;
        end else begin
            fetchLoad <= 1'b0;
            case (state_q)
                `ST_IDLE: begin
                    if (dbgReq) begin
                        type_q  <= DBG_TYPE;
                        state_q <= `ST_DRAIN;
                    end else if (excReq) begin
                        type_q  <= excType;
                        state_q <= `ST_DRAIN;
                    end else if (rfiReq) begin
                        fetchLoad <= 1'b1;
                        fetchAddr <= saved_return_address_reg_q;
                    end
                end
                `ST_DRAIN: begin
                    if (!coreBusy)
                        state_q <= `ST_SAVE;
                end
                `ST_SAVE: begin
                    state_q <= `ST_JUMP;
                end
                `ST_JUMP: begin
                    fetchLoad <= 1'b1;
                    fetchAddr <= vector;
                    state_q   <= `ST_IDLE;
                end
                default: begin
                    state_q <= `ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Machine state and save/restore registers
    // ****************************************************************
    // Hardware sequencing wins over a software write in the same cycle,
    // so saved state can never be half software, half hardware.
    // A bus write lost this way is still acknowledged; software must not
    // touch these registers while an entry or return is under way.
    always @* begin
        msr_d  = msr_q;
        saved_return_address_reg_d = saved_return_address_reg_q;
        saved_machine_state_reg_d = saved_machine_state_reg_q;
        if (saveCycle) begin
            saved_return_address_reg_d = nextPc;
            saved_machine_state_reg_d = {16'h0000, msr_q[`MSR_SAVED_HI:0]};
        end else if (jumpCycle) begin
            msr_d[`MSR_EE_BIT] = 1'b0;
            msr_d[`MSR_RI_BIT] = 1'b0;
        end else if (rfiTake) begin
            msr_d[`MSR_SAVED_HI:0] = saved_machine_state_reg_q[`MSR_SAVED_HI:0];
        end else if (wrStb) begin
            case (wordAdr)
                `OFS_MACHINE_STATE: begin
                    msr_d = (msr_q & ~wrMask) | (wbDatI & wrMask);
                end
                `OFS_SAVED_RETURN: begin
                    saved_return_address_reg_d = (saved_return_address_reg_q & ~wrMask) | (wbDatI & wrMask);
                end
                `OFS_SAVED_STATE: begin
                    saved_machine_state_reg_d = (saved_machine_state_reg_q & ~wrMask) | (wbDatI & wrMask);
                end
                `OFS_SET_EN_RECOV: begin
                    msr_d[`MSR_EE_BIT] = 1'b1;
                    msr_d[`MSR_RI_BIT] = 1'b1;
                end
                `OFS_SET_RECOV_ONLY: begin
                    msr_d[`MSR_RI_BIT] = 1'b1;
                end
                default: begin
                    msr_d = msr_q;
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            msr_q  <= `MSR_RESET;
            saved_return_address_reg_q <= `SRR_RESET;
            saved_machine_state_reg_q <= `SRR_RESET;
        end else begin
            msr_q  <= msr_d;
            saved_return_address_reg_q <= saved_return_address_reg_d;
            saved_machine_state_reg_q <= saved_machine_state_reg_d;
        end
    end

    // ****************************************************************
    // Wishbone answer
    // ****************************************************************
    // Registers are only seen as bus words handed to a general register;
    // there is no memory-store path from them.
    always @(posedge mclk) begin
        if (!resetn) begin
            wbAck  <= 1'b0;
            wbDatO <= 32'h00000000;
        end else begin
            wbAck  <= busReq;
            wbDatO <= 32'h00000000;
            if (busReq && !wbWe) begin
                case (wordAdr)
                    `OFS_MACHINE_STATE: wbDatO <= msr_q;
                    `OFS_SAVED_RETURN:  wbDatO <= saved_return_address_reg_q;
                    `OFS_SAVED_STATE:   wbDatO <= saved_machine_state_reg_q;
                    `OFS_UNIT_STATUS:   wbDatO <= {{(28-TYPE_W){1'b0}}, type_q, state_q};
                    default:            wbDatO <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
